/* File: common/irq_status_pkg.sv */
`default_nettype none
package irq_status_pkg;

   // Bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_RELOAD = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h8;

   // Word index decode
   localparam int IDX_HI = 3;
   localparam int IDX_LO = 2;

   // Status word field layout
   localparam int PRIO_W   = 3;
   localparam int REQ_W    = 8;
   localparam int PRIO_LSB = 8;
   localparam int REQ_LSB  = 0;
   localparam int USED_W   = PRIO_W + REQ_W;
   localparam int PAD_W    = DATA_W - USED_W;

   // Reset values and the count step
   localparam logic [PRIO_W-1:0] PRIO_RST   = 3'h0;
   localparam logic [REQ_W-1:0]  REQ_RST    = 8'h00;
   localparam logic [DATA_W-1:0] RELOAD_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;
   localparam logic [DATA_W-1:0] COUNT_ONE  = 32'h0000_0001;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed
   {
      logic [PAD_W-1:0]  pad;
      logic [PRIO_W-1:0] prio;
      logic [REQ_W-1:0]  req;
   } status_word_t;

   // Event from the controller core, same clock
   typedef struct packed
   {
      logic              presented;
      logic [PRIO_W-1:0] prio;
      logic              serviced;
      logic [REQ_W-1:0]  req;
      logic              trigger;
   } irq_event_t;

   typedef enum logic [1:0]
   {
      SEL_STATUS,
      SEL_RELOAD,
      SEL_COUNT,
      SEL_NONE
   } reg_sel_t;

endpackage
`default_nettype wire

/* File: rtl/irq_status_regs.sv */
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
// How it works
// - Bits 10 to 8 of the status word hold the latest presented priority.
// - Bits 7 to 0 hold the number of the request the core serviced last.
// - Both status fields reset to zero and change only by hardware.
// - Bits 31 to 11 of the status word always read as zero.
// - The reload register is 32 bits, read/write, and resets to zero.
// - An interrupt trigger loads the proximity timer from the reload value.
module irq_status_regs
(
   // Clock, reset, enable
   input  wire logic                                  ref_clk,
   input  wire logic                                  rst_n,
   input  wire logic                                  ce,
   // Controller core events
   input  wire irq_status_pkg::irq_event_t            irq_event,
   // Proximity timer
   output var  logic                                  prox_running,
   output var  logic                                  prox_expired,
   // AXI4-Lite write address
   input  wire logic                                  s_axi_awvalid,
   output var  logic                                  s_axi_awready,
   input  wire logic [irq_status_pkg::ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic [2:0]                            s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic                                  s_axi_wvalid,
   output var  logic                                  s_axi_wready,
   input  wire logic [irq_status_pkg::DATA_W-1:0]     s_axi_wdata,
   input  wire logic [irq_status_pkg::STRB_W-1:0]     s_axi_wstrb,
   // AXI4-Lite write response
   output var  logic                                  s_axi_bvalid,
   input  wire logic                                  s_axi_bready,
   output var  logic [1:0]                            s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                                  s_axi_arvalid,
   output var  logic                                  s_axi_arready,
   input  wire logic [irq_status_pkg::ADDR_W-1:0]     s_axi_araddr,
   input  wire logic [2:0]                            s_axi_arprot,
   // AXI4-Lite read data
   output var  logic                                  s_axi_rvalid,
   input  wire logic                                  s_axi_rready,
   output var  logic [irq_status_pkg::DATA_W-1:0]     s_axi_rdata,
   output var  logic [1:0]                            s_axi_rresp
);

   function automatic irq_status_pkg::reg_sel_t decode
   (
      input logic [irq_status_pkg::ADDR_W-1:0] addr
   );
      irq_status_pkg::reg_sel_t sel;
      sel = irq_status_pkg::SEL_NONE;
      if (addr[irq_status_pkg::IDX_HI:irq_status_pkg::IDX_LO] ==
          irq_status_pkg::OFS_STATUS[irq_status_pkg::IDX_HI:
                                     irq_status_pkg::IDX_LO])
         sel = irq_status_pkg::SEL_STATUS;
      else if (addr[irq_status_pkg::IDX_HI:irq_status_pkg::IDX_LO] ==
               irq_status_pkg::OFS_RELOAD[irq_status_pkg::IDX_HI:
                                          irq_status_pkg::IDX_LO])
         sel = irq_status_pkg::SEL_RELOAD;
      else if (addr[irq_status_pkg::IDX_HI:irq_status_pkg::IDX_LO] ==
               irq_status_pkg::OFS_COUNT[irq_status_pkg::IDX_HI:
                                         irq_status_pkg::IDX_LO])
         sel = irq_status_pkg::SEL_COUNT;
      return sel;
   endfunction

   // Byte-lane merge of a write into a stored word
   function automatic logic [irq_status_pkg::DATA_W-1:0] merge
   (
      input logic [irq_status_pkg::DATA_W-1:0] old_word,
      input logic [irq_status_pkg::DATA_W-1:0] new_word,
      input logic [irq_status_pkg::STRB_W-1:0] strb
   );
      logic [irq_status_pkg::DATA_W-1:0] res;
      res = old_word;
      for (int i = 0; i < irq_status_pkg::STRB_W; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = new_word[i*8 +: 8];
      end
      return res;
   endfunction

   logic [irq_status_pkg::PRIO_W-1:0]  prio_q;
   logic [irq_status_pkg::REQ_W-1:0]   req_q;
   logic [irq_status_pkg::DATA_W-1:0]  reload_q;
   logic [irq_status_pkg::DATA_W-1:0]  count_q;
   logic [irq_status_pkg::ADDR_W-1:0]  awaddr_q;
   logic [irq_status_pkg::DATA_W-1:0]  wdata_q;
   logic [irq_status_pkg::STRB_W-1:0]  wstrb_q;
   logic                               aw_have_q;
   logic                               w_have_q;
   irq_status_pkg::status_word_t       status_word;
   logic                               aw_fire;
   logic                               w_fire;
   logic                               wr_go;
   logic                               ar_fire;
   irq_status_pkg::reg_sel_t           wr_sel;
   irq_status_pkg::reg_sel_t           rd_sel;

   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire  = s_axi_wvalid && s_axi_wready;
   assign wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign wr_sel  = decode(awaddr_q);
   assign rd_sel  = decode(s_axi_araddr);

   // Upper bits are hard zero, not storage
   assign status_word.pad  = '0;
   assign status_word.prio = prio_q;
   assign status_word.req  = req_q;

   // Status fields follow the core only; no bus path reaches them
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         prio_q <= irq_status_pkg::PRIO_RST;
         req_q  <= irq_status_pkg::REQ_RST;
      end
      else if (ce)
      begin
         if (irq_event.presented)
            prio_q <= irq_event.prio;
         if (irq_event.serviced)
            req_q <= irq_event.req;
      end
   end

   // Write address and data are latched separately, in either order
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
      end
      else if (ce)
      begin
         if (aw_fire)
         begin
            aw_have_q     <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q      <= s_axi_awaddr;
         end
         if (w_fire)
         begin
            w_have_q     <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
         // Ready returns only after the response is taken: one write at a time
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= irq_status_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            // Writes to read-only words are dropped but acknowledged
            s_axi_bresp  <= (wr_sel == irq_status_pkg::SEL_NONE) ?
                            irq_status_pkg::RESP_SLVERR :
                            irq_status_pkg::RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         reload_q <= irq_status_pkg::RELOAD_RST;
      else if (ce && wr_go && wr_sel == irq_status_pkg::SEL_RELOAD)
         reload_q <= merge(reload_q, wdata_q, wstrb_q);
   end

   // Read channel: data registered one cycle after the address is taken
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= irq_status_pkg::WORD_ZERO;
         s_axi_rresp   <= irq_status_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (ar_fire)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= irq_status_pkg::RESP_OKAY;
            case (rd_sel)
               irq_status_pkg::SEL_STATUS:
                  s_axi_rdata <= status_word;
               irq_status_pkg::SEL_RELOAD:
                  s_axi_rdata <= reload_q;
               irq_status_pkg::SEL_COUNT:
                  s_axi_rdata <= count_q;
               default:
               begin
                  s_axi_rdata <= irq_status_pkg::WORD_ZERO;
                  s_axi_rresp <= irq_status_pkg::RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Proximity timer; a trigger while counting restarts it
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         count_q      <= irq_status_pkg::WORD_ZERO;
         prox_running <= 1'b0;
         prox_expired <= 1'b0;
      end
      else if (ce)
      begin
         prox_expired <= 1'b0;
         if (irq_event.trigger)
         begin
            count_q      <= reload_q;
            prox_running <= 1'b1;
         end
         else if (prox_running)
         begin
            if (count_q == irq_status_pkg::WORD_ZERO)
            begin
               prox_running <= 1'b0;
               prox_expired <= 1'b1;
            end
            else
               count_q <= count_q - irq_status_pkg::COUNT_ONE;
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_write_both;
      ce && wr_go;
   endsequence

   a_prio_tracks_core: assert property (
      ce && irq_event.presented |=> prio_q == $past(irq_event.prio))
      else $error("presented priority not captured");

   a_req_tracks_core: assert property (
      ce && irq_event.serviced |=> req_q == $past(irq_event.req))
      else $error("serviced request not captured");

   a_status_hw_only: assert property (
      !(ce && irq_event.presented) |=> $stable(prio_q))
      else $error("priority field changed without an event");

   a_req_hw_only: assert property (
      !(ce && irq_event.serviced) |=> $stable(req_q))
      else $error("request field changed without an event");

   a_status_upper_zero: assert property (
      ce && ar_fire && rd_sel == irq_status_pkg::SEL_STATUS |=>
      s_axi_rdata[irq_status_pkg::DATA_W-1:irq_status_pkg::USED_W] == '0
      && s_axi_rdata[irq_status_pkg::USED_W-1:0] == $past(status_word[
         irq_status_pkg::USED_W-1:0]))
      else $error("status read wrong");

   a_reload_write: assert property (
      s_write_both ##0 (wr_sel == irq_status_pkg::SEL_RELOAD
                        && wstrb_q == '1)
      |=> reload_q == $past(wdata_q))
      else $error("reload register not written");

   a_write_response: assert property (
      s_write_both |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
      else $error("write response missing");

   a_timer_load: assert property (
      ce && irq_event.trigger |=> prox_running
      && count_q == $past(reload_q))
      else $error("timer not loaded from reload");

   a_timer_expiry: assert property (
      ce && prox_running && !irq_event.trigger
      && count_q == irq_status_pkg::WORD_ZERO
      |=> prox_expired && !prox_running)
      else $error("timer expiry missed");

   a_timer_counts: assert property (
      ce && prox_running && !irq_event.trigger
      && count_q != irq_status_pkg::WORD_ZERO
      |=> count_q == $past(count_q) - irq_status_pkg::COUNT_ONE)
      else $error("timer did not count down");

endmodule
`default_nettype wire

/* File: dv/irq_core_model.sv */
`default_nettype none
module irq_core_model
(
   // Clock
   input  wire logic                       ref_clk,
   // Events toward the status block
   output var  irq_status_pkg::irq_event_t irq_event
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      irq_event = '0;
   end

   // Kind bits: 0 present, 1 service, 2 trigger; lag models a slow core
   task automatic raise(input logic [2:0] kind, input logic [7:0] v,
                        input int lag);
      repeat (lag + 1) @(posedge ref_clk);
      // Priority presented as in single-vector operation
      irq_event.presented <= kind[0];
      irq_event.prio      <= v[2:0];
      irq_event.serviced  <= kind[1];
      irq_event.req       <= v;
      irq_event.trigger   <= kind[2];
      @(posedge ref_clk);
      // Stale payload is inverted so nothing relies on a held value
      irq_event.presented <= 1'b0;
      irq_event.prio      <= ~v[2:0];
      irq_event.serviced  <= 1'b0;
      irq_event.req       <= ~v;
      irq_event.trigger   <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: dv/interrupt_status_and_proximity_reload_tb.sv */
`default_nettype none
module interrupt_status_and_proximity_reload_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic                       ref_clk, rst_n, prox_running, prox_expired;
   logic                       ce;
   irq_status_pkg::irq_event_t irq_event;
   logic                       awvalid, awready, wvalid, wready, bvalid;
   logic                       bready, arvalid, arready, rvalid, rready;
   logic [3:0]                 awaddr, araddr, wstrb;
   logic [31:0]                wdata, rdata, rd;
   logic [1:0]                 bresp, rresp, resp;
   int                         err_total, checked, cycles, n;

   irq_status_regs u_irq_status_regs
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .irq_event(irq_event),
      .prox_running(prox_running), .prox_expired(prox_expired),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp)
   );

   irq_core_model u_irq_core_model
   (
      .ref_clk(ref_clk), .irq_event(irq_event)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Bus tasks enter one edge late so a released strobe never flips twice
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done && bvalid))
      begin
         @(posedge ref_clk);
         if (bvalid && aw_done && w_done)
            r = bresp;
         if (awready && !aw_done)
         begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w_done)
         begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         finish_test();
      end
   end

   initial
   begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      ce = 1'b1;
      {awaddr, araddr, wstrb, wdata} = '0;
      {err_total, checked, cycles} = '0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      axi_read(4'h0, rd, resp);
      check(rd, 32'h0000_0000);
      axi_read(4'h4, rd, resp);
      check(rd, 32'h0000_0000);
      axi_write(4'h4, 32'hA5A5_5A5A, 4'hF, resp);
      check({30'h0, resp}, 32'h0000_0000);
      axi_write(4'h4, 32'hFFFF_FFFF, 4'h1, resp);
      axi_read(4'h4, rd, resp);
      check(rd, 32'hA5A5_5AFF);
      axi_write(4'hC, 32'h1234_5678, 4'hF, resp);
      check({30'h0, resp}, 32'h0000_0002);
      axi_read(4'hC, rd, resp);
      check({rd[29:0], resp}, 32'h0000_0002);
      for (int p = 0; p < 8; p++)
      begin
         u_irq_core_model.raise(3'h1, 8'(p), p % 2);
         u_irq_core_model.raise(3'h2, 8'(8'hC0 + 8'(p * 5)), 0);
         axi_write(4'h0, 32'hFFFF_FFFF, 4'hF, resp);
         axi_read(4'h0, rd, resp);
         check(rd, {21'h000000, 3'(p), 8'(8'hC0 + 8'(p * 5))});
      end
      for (int i = 0; i < 3; i++)
      begin
         axi_write(4'h4, 32'(i * 3), 4'hF, resp);
         u_irq_core_model.raise(3'h4, 8'h00, 0);
         #1;
         check({31'h0, prox_running}, 32'h0000_0001);
         n = 0;
         do
         begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         while (!prox_expired && n < 100);
         check(32'(n), 32'(i * 3 + 1));
      end
      // Count word seen one clock after a long load
      axi_write(4'h4, 32'h0000_0100, 4'hF, resp);
      u_irq_core_model.raise(3'h4, 8'h00, 0);
      axi_read(4'h8, rd, resp);
      check(rd, 32'h0000_00FF);
      // Retrigger with a short load, then freeze four clocks with ce low
      axi_write(4'h4, 32'h0000_0003, 4'hF, resp);
      u_irq_core_model.raise(3'h4, 8'h00, 0);
      ce <= 1'b0;
      repeat (4) @(posedge ref_clk);
      ce <= 1'b1;
      #1;
      check({30'h0, prox_running, prox_expired}, 32'h0000_0002);
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      while (!prox_expired && n < 100);
      check(32'(n), 32'h0000_0004);
      axi_read(4'h8, rd, resp);
      check(rd, 32'h0000_0000);
      finish_test();
   end
endmodule
`default_nettype wire
